// ==== rtl/rstc_pkg.sv ====
package rstc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [31:0] RSTC_CTRL_OFF  = 32'h0000_0000;
  localparam logic [31:0] RSTC_CAUSE_OFF = 32'h0000_0004;
  localparam logic [31:0] RSTC_STRAP_OFF = 32'h0000_0008;
  localparam logic [31:0] RSTC_CFG_OFF   = 32'h0000_000C;
  localparam logic [31:0] RSTC_ISTAT_OFF = 32'h0000_0010;
  localparam logic [31:0] RSTC_IMASK_OFF = 32'h0000_0014;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int RSTC_CTRL_WDOG_EN   = 0;
  localparam int RSTC_CTRL_BMON_EN   = 1;
  localparam logic [1:0] RSTC_CTRL_RESET = 2'h3;

  // Cause and interrupt status share this layout
  localparam int RSTC_EV_POR     = 0;
  localparam int RSTC_EV_EXTHARD = 1;
  localparam int RSTC_EV_WDOG    = 2;
  localparam int RSTC_EV_BMON    = 3;
  localparam int RSTC_EV_SOFT    = 4;
  localparam int RSTC_EV_PORSHRT = 5;
  localparam int RSTC_EV_W       = 6;
  localparam logic [RSTC_EV_W-1:0] RSTC_EV_RESET  = 6'h00;
  localparam logic [RSTC_EV_W-1:0] RSTC_MASK_RESET = 6'h00;

  // Strap register: [1:0] boot mode, [2] wdog, [3] narrow bus,
  // [4] host mode, [5] config source (1 = serial memory)
  localparam int RSTC_STRAP_BM    = 0;
  localparam int RSTC_STRAP_WATCHDOG_ENABLE_STRAP  = 2;
  localparam int RSTC_STRAP_NARW  = 3;
  localparam int RSTC_STRAP_HMODE = 4;
  localparam int RSTC_STRAP_SRC   = 5;
  localparam logic [1:0] RSTC_BM_HOST = 2'h0;

  localparam logic [1:0] RSTC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RSTC_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing, in input reference clock periods
  // ---------------------------------------------------------------
  localparam int RSTC_INPUT_REFERENCE_CLOCK_PER_CLK = 1;
  localparam int RSTC_POR_MIN_INPUT_REFERENCE_CLOCK = 16;
  localparam int RSTC_RELEASE_INPUT_REFERENCE_CLOCK = 521;
  localparam int RSTC_SOFT_INPUT_REFERENCE_CLOCK    = 16;
  localparam int RSTC_CNT_W         = 10;
  localparam logic [RSTC_CNT_W-1:0] RSTC_POR_MIN_CYC =
    RSTC_CNT_W'(RSTC_POR_MIN_INPUT_REFERENCE_CLOCK * RSTC_INPUT_REFERENCE_CLOCK_PER_CLK);
  localparam logic [RSTC_CNT_W-1:0] RSTC_RELEASE_CYC =
    RSTC_CNT_W'(RSTC_RELEASE_INPUT_REFERENCE_CLOCK * RSTC_INPUT_REFERENCE_CLOCK_PER_CLK);
  localparam logic [RSTC_CNT_W-1:0] RSTC_SOFT_CYC =
    RSTC_CNT_W'(RSTC_SOFT_INPUT_REFERENCE_CLOCK * RSTC_INPUT_REFERENCE_CLOCK_PER_CLK);

  typedef enum logic [2:0] {
    RSTC_POR_HOLD,
    RSTC_POR_REL,
    RSTC_HARD_DRIVE,
    RSTC_HARD_WAIT,
    RSTC_SOFT_HOLD,
    RSTC_RUN
  } rstc_state_e;

endpackage : rstc_pkg

// ==== rtl/rstc_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser; the first stage feeds only the second
module rstc_sync #(
  parameter int          W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : rstc_sync

// ==== rtl/rstc_top.sv ====
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module rstc_top
  import rstc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Reset pins
  input  wire logic        power_on_reset_n_in,
  input  wire logic        hard_reset_pin_n_in,
  output logic             hard_reset_pin_n_out,
  output logic             hard_reset_pin_oe_n_out,
  // Internal reset events
  input  wire logic        watchdog_expired_in,
  input  wire logic        bus_monitor_expired_in,
  input  wire logic        tap_boundary_instr_in,
  // Straps
  input  wire logic [1:0]  boot_mode_select_in,
  input  wire logic        watchdog_enable_strap_in,
  input  wire logic        host_narrow_bus_strap_in,
  input  wire logic        host_mode_strap_in,
  // Configuration sources
  input  wire logic        cfg_host_valid_in,
  input  wire logic [31:0] cfg_host_data_in,
  input  wire logic        cfg_i2c_valid_in,
  input  wire logic [31:0] cfg_i2c_data_in,
  // Reset outputs
  output logic             system_pll_reset_out,
  output logic             core_reset_out,
  output logic             periph_reset_out,
  output logic             timer_reset_out,
  output logic             stop_halt_reset_out,
  output logic             soft_reset_internal_out,
  // Captured configuration
  output logic [1:0]       boot_mode_select_out,
  output logic             watchdog_enable_out,
  output logic             host_narrow_bus_out,
  output logic             host_mode_out,
  output logic             cfg_from_i2c_out,
  output logic [31:0]      cfg_word_out,
  // Interrupt
  output logic             irq_out
);

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pins_sync;

  rstc_sync #(
    .W       (2),
    .RST_VAL (2'h0)
  ) i_rstc_sync (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .async_in ({hard_reset_pin_n_in, power_on_reset_n_in}),
    .sync_out (pins_sync)
  );

  wire por_active  = !pins_sync[0];
  wire pin_low     = !pins_sync[1];

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  rstc_state_e                state_reg;
  rstc_state_e                state_next;
  logic [RSTC_CNT_W-1:0]      cnt_reg;
  logic [RSTC_CNT_W-1:0]      cnt_next;
  logic [RSTC_CNT_W-1:0]      por_len_reg;
  logic [1:0]                 ctrl_reg;
  logic [RSTC_EV_W-1:0]       cause_reg;
  logic [RSTC_EV_W-1:0]       istat_reg;
  logic [RSTC_EV_W-1:0]       imask_reg;
  logic [5:0]                 strap_reg;
  logic [31:0]                cfg_reg;

  // ---------------------------------------------------------------
  // Reset sources and flow starts
  // ---------------------------------------------------------------
  wire in_run     = (state_reg == RSTC_RUN);
  wire wdog_hit   = watchdog_expired_in
                    && ctrl_reg[RSTC_CTRL_WDOG_EN];
  wire bmon_hit   = bus_monitor_expired_in
                    && ctrl_reg[RSTC_CTRL_BMON_EN];
  // The pin reads low while we drive it, so only sample it in run
  wire ext_hit    = pin_low && in_run;
  wire hard_start = in_run && !por_active
                    && (ext_hit || wdog_hit || bmon_hit);
  wire soft_start = in_run && !por_active && !hard_start
                    && tap_boundary_instr_in;
  wire por_start  = por_active && (state_reg != RSTC_POR_HOLD);
  wire por_release = (state_reg == RSTC_POR_HOLD) && !por_active;
  wire por_short  = por_release
                    && (por_len_reg < RSTC_POR_MIN_CYC);
  wire cnt_done   = (cnt_reg == '0);

  // Event vector in cause layout
  logic [RSTC_EV_W-1:0] ev_vec;
  assign ev_vec[RSTC_EV_POR]     = por_start;
  assign ev_vec[RSTC_EV_EXTHARD] = hard_start && ext_hit;
  assign ev_vec[RSTC_EV_WDOG]    = hard_start && wdog_hit;
  assign ev_vec[RSTC_EV_BMON]    = hard_start && bmon_hit;
  assign ev_vec[RSTC_EV_SOFT]    = soft_start;
  assign ev_vec[RSTC_EV_PORSHRT] = por_short;

  wire new_cause = por_start || hard_start || soft_start;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_done ? cnt_reg : cnt_reg - 1'b1;
    unique case (state_reg)
      RSTC_POR_HOLD: begin
        if (!por_active) begin
          state_next = RSTC_POR_REL;
          cnt_next   = RSTC_RELEASE_CYC - 1'b1;
        end
      end
      RSTC_POR_REL: begin
        if (cnt_done) begin
          state_next = RSTC_HARD_WAIT;
        end
      end
      RSTC_HARD_DRIVE: begin
        if (cnt_done) begin
          state_next = RSTC_HARD_WAIT;
        end
      end
      RSTC_HARD_WAIT: begin
        // Board circuitry may still hold the pin low
        if (!pin_low) begin
          state_next = RSTC_RUN;
        end
      end
      RSTC_SOFT_HOLD: begin
        if (cnt_done) begin
          state_next = RSTC_RUN;
        end
      end
      RSTC_RUN: begin
        if (hard_start) begin
          state_next = RSTC_HARD_DRIVE;
          cnt_next   = RSTC_RELEASE_CYC - 1'b1;
        end else if (soft_start) begin
          state_next = RSTC_SOFT_HOLD;
          cnt_next   = RSTC_SOFT_CYC - 1'b1;
        end
      end
      default: begin
        state_next = RSTC_POR_HOLD;
      end
    endcase
    if (por_start) begin
      state_next = RSTC_POR_HOLD;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      // Leave reset in run so a pin still low is logged as power-on
      state_reg <= RSTC_RUN;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Length of the power-on pulse, saturating at the minimum
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      por_len_reg <= '0;
    end else if (!por_active) begin
      por_len_reg <= '0;
    end else if (por_len_reg < RSTC_POR_MIN_CYC) begin
      por_len_reg <= por_len_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Reset outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      system_pll_reset_out    <= 1'b1;
      hard_reset_pin_oe_n_out <= 1'b0;
      core_reset_out          <= 1'b1;
      soft_reset_internal_out <= 1'b0;
    end else begin
      system_pll_reset_out    <= (state_next == RSTC_POR_HOLD);
      hard_reset_pin_oe_n_out <= !(state_next == RSTC_POR_HOLD
                                 || state_next == RSTC_POR_REL
                                 || state_next == RSTC_HARD_DRIVE);
      core_reset_out          <= (state_next != RSTC_RUN);
      soft_reset_internal_out <= (state_next == RSTC_SOFT_HOLD);
    end
  end

  // Open-drain: only ever drive low
  assign hard_reset_pin_n_out = 1'b0;
  assign periph_reset_out     = core_reset_out;
  assign timer_reset_out      = core_reset_out;
  assign stop_halt_reset_out  = core_reset_out;

  // ---------------------------------------------------------------
  // Straps and configuration capture
  // ---------------------------------------------------------------
  wire [5:0] strap_live = {boot_mode_select_in != RSTC_BM_HOST,
                           host_mode_strap_in,
                           host_narrow_bus_strap_in,
                           watchdog_enable_strap_in,
                           boot_mode_select_in};
  wire use_i2c   = strap_reg[RSTC_STRAP_SRC];
  wire cfg_take  = (state_reg == RSTC_POR_REL) && !por_active
                   && (use_i2c ? cfg_i2c_valid_in
                               : cfg_host_valid_in);
  wire [31:0] cfg_src = use_i2c ? cfg_i2c_data_in : cfg_host_data_in;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      strap_reg <= '0;
      cfg_reg   <= '0;
    end else begin
      if (por_release) begin
        strap_reg <= strap_live;
      end
      if (cfg_take) begin
        cfg_reg <= cfg_src;
      end
    end
  end

  assign boot_mode_select_out = strap_reg[RSTC_STRAP_BM +: 2];
  assign watchdog_enable_out  = strap_reg[RSTC_STRAP_WATCHDOG_ENABLE_STRAP];
  assign host_narrow_bus_out  = strap_reg[RSTC_STRAP_NARW];
  assign host_mode_out        = strap_reg[RSTC_STRAP_HMODE];
  assign cfg_from_i2c_out     = use_i2c;
  assign cfg_word_out         = cfg_reg;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_fire  = s_axi_awvalid && s_axi_awready;
  wire w_fire   = s_axi_wvalid && s_axi_wready;
  wire ar_fire  = s_axi_arvalid && s_axi_arready;
  wire wr_go    = aw_held_reg && w_held_reg;
  wire wr_ctrl  = wr_go && wstrb0_reg && (awaddr_reg == RSTC_CTRL_OFF);
  wire wr_istat = wr_go && wstrb0_reg && (awaddr_reg == RSTC_ISTAT_OFF);
  wire wr_imask = wr_go && wstrb0_reg && (awaddr_reg == RSTC_IMASK_OFF);
  wire wr_hit   = (awaddr_reg == RSTC_CTRL_OFF)
                  || (awaddr_reg == RSTC_ISTAT_OFF)
                  || (awaddr_reg == RSTC_IMASK_OFF)
                  || (awaddr_reg == RSTC_CAUSE_OFF)
                  || (awaddr_reg == RSTC_STRAP_OFF)
                  || (awaddr_reg == RSTC_CFG_OFF);

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= '0;
      wstrb0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RSTC_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[31:2], 2'h0};
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RSTC_RESP_OKAY : RSTC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode
  wire [31:0] ar_addr = {s_axi_araddr[31:2], 2'h0};
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (ar_addr)
      RSTC_CTRL_OFF:  rd_mux = {30'h0, ctrl_reg};
      RSTC_CAUSE_OFF: rd_mux = {26'h0, cause_reg};
      RSTC_STRAP_OFF: rd_mux = {26'h0, strap_reg};
      RSTC_CFG_OFF:   rd_mux = cfg_reg;
      RSTC_ISTAT_OFF: rd_mux = {26'h0, istat_reg};
      RSTC_IMASK_OFF: rd_mux = {26'h0, imask_reg};
      default: begin
        rd_mux = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RSTC_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RSTC_RESP_OKAY : RSTC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control, cause and interrupt registers
  // ---------------------------------------------------------------
  // Sticky bits: a new event in the clearing cycle wins
  wire [RSTC_EV_W-1:0] istat_clr = wr_istat ? wdata_reg[RSTC_EV_W-1:0]
                                            : '0;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ctrl_reg  <= RSTC_CTRL_RESET;
      cause_reg <= RSTC_EV_RESET;
      istat_reg <= RSTC_EV_RESET;
      imask_reg <= RSTC_MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata_reg[1:0];
      end
      // Survives every flow so software can read it afterwards
      if (new_cause) begin
        cause_reg <= ev_vec;
      end else if (por_short) begin
        cause_reg[RSTC_EV_PORSHRT] <= 1'b1;
      end
      istat_reg <= (istat_reg & ~istat_clr) | ev_vec;
      if (wr_imask) begin
        imask_reg <= wdata_reg[RSTC_EV_W-1:0];
      end
    end
  end

  assign irq_out = |(istat_reg & imask_reg);

endmodule : rstc_top

// ==== verif/rstc_monitor.sv ====
`timescale 1ns/1ps
module rstc_monitor
  import rstc_pkg::*;
(
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        rstn_in,
  // Watched ports
  input wire logic        power_on_reset_n_in,
  input wire logic        hard_reset_pin_n_out,
  input wire logic        hard_reset_pin_oe_n_out,
  input wire logic        system_pll_reset_out,
  input wire logic        core_reset_out,
  input wire logic        periph_reset_out,
  input wire logic        timer_reset_out,
  input wire logic        stop_halt_reset_out,
  input wire logic        soft_reset_internal_out,
  input wire logic [1:0]  boot_mode_select_out,
  input wire logic [31:0] cfg_word_out
);
  // ------------------------------------------------------------
  // Pin low time, saturating so a long hold cannot wrap
  // ------------------------------------------------------------
  logic [9:0] low_cnt;
  logic       por_flow;

  // Set from power-on until the pin is let go; hard flows never set it
  always_ff @(posedge clock_in) begin
    if (!rstn_in || !power_on_reset_n_in)
      por_flow <= 1'b1;
    else if (hard_reset_pin_oe_n_out)
      por_flow <= 1'b0;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in || hard_reset_pin_oe_n_out)
      low_cnt <= 10'h000;
    else if (low_cnt != 10'h3FF)
      low_cnt <= low_cnt + 10'h001;
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  a_pin_low_only: assert property (hard_reset_pin_n_out == 1'b0)
    else $error("Hard reset pin driven high");
  a_pll_por_only: assert property (
    $rose(system_pll_reset_out) |-> !power_on_reset_n_in)
    else $error("PLL reset without power-on reset");
  a_pll_full_reset: assert property (
    system_pll_reset_out |-> core_reset_out && !hard_reset_pin_oe_n_out)
    else $error("Power-on reset misses core or pin");
  a_soft_no_pin: assert property (
    soft_reset_internal_out |-> hard_reset_pin_oe_n_out && core_reset_out)
    else $error("Soft reset drives the pin");
  a_group_reset: assert property (
    {periph_reset_out, timer_reset_out, stop_halt_reset_out}
      == {3{core_reset_out}})
    else $error("Reset outputs disagree");
  a_pin_with_core: assert property (
    !hard_reset_pin_oe_n_out |-> core_reset_out)
    else $error("Pin driven while core runs");
  a_strap_keep: assert property (
    $changed(boot_mode_select_out) |-> $past(system_pll_reset_out))
    else $error("Straps changed outside power-on reset");
  a_cfg_keep: assert property (
    $changed(cfg_word_out) |-> $past(por_flow) && !soft_reset_internal_out)
    else $error("Config word changed outside power-on reset");
  a_release_gap: assert property (
    $rose(hard_reset_pin_oe_n_out) |-> low_cnt >= 10'h209)
    else $error("Hard reset pin released early");
endmodule : rstc_monitor

// ==== verif/rstc_board.sv ====
`timescale 1ns/1ps
module rstc_board (
  // Clock
  input  wire logic clock_in,
  // Device side of the pin
  input  wire logic oe_n_in,
  // Board reset lines
  output logic      por_n_out,
  output wire logic pin_n_out
);
  logic ext_low;

  // Pull-up: pin high unless either party pulls it low
  assign pin_n_out = !(ext_low || !oe_n_in);

  initial begin
    por_n_out = 1'b0;
    ext_low   = 1'b0;
  end

  task automatic por_cycle(input int hold);
    @(posedge clock_in);
    por_n_out <= 1'b0;
    repeat (hold) @(posedge clock_in);
    por_n_out <= 1'b1;
  endtask : por_cycle

  task automatic pull_pin(input int n);
    @(posedge clock_in);
    ext_low <= 1'b1;
    repeat (n) @(posedge clock_in);
    ext_low <= 1'b0;
  endtask : pull_pin
endmodule : rstc_board

// ==== verif/test_reset_controller.sv ====
`timescale 1ns/1ps
module test_reset_controller;
  import rstc_pkg::*;
  logic        clock_in, rstn_in, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] cfg_host_data_in, cfg_i2c_data_in, cfg_word_out, rd;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [1:0]  boot_mode_select_in, boot_mode_select_out;
  logic        power_on_reset_n_in, hard_reset_pin_n_in;
  logic        hard_reset_pin_n_out, hard_reset_pin_oe_n_out;
  logic        watchdog_enable_strap_in, host_narrow_bus_strap_in;
  logic        host_mode_strap_in, system_pll_reset_out, core_reset_out;
  logic        periph_reset_out, timer_reset_out, stop_halt_reset_out;
  logic        soft_reset_internal_out, watchdog_enable_out, irq_out;
  logic        host_narrow_bus_out, host_mode_out, cfg_from_i2c_out;
  logic [4:0]  ev;
  wire         watchdog_expired_in = ev[0];
  wire         bus_monitor_expired_in = ev[1];
  wire         tap_boundary_instr_in = ev[2];
  wire         cfg_host_valid_in = ev[3];
  wire         cfg_i2c_valid_in = ev[4];
  wire  [5:0]  st_out = {cfg_from_i2c_out, host_mode_out,
                         host_narrow_bus_out, watchdog_enable_out,
                         boot_mode_select_out};
  int          fails, check_count, n;

  rstc_top i_rstc_top (.*);
  rstc_board i_rstc_board (
    .clock_in  (clock_in),
    .oe_n_in   (hard_reset_pin_oe_n_out),
    .por_n_out (power_on_reset_n_in),
    .pin_n_out (hard_reset_pin_n_in)
  );

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [31:0] a, d, input logic [1:0] re);
    logic at, wt, ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clock_in);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clock_in);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      @(posedge clock_in);
      if (at === 1'b1) s_axi_awvalid <= 1'b0;
      if (wt === 1'b1) s_axi_wvalid <= 1'b0;
      ad |= (at === 1'b1);
      wd |= (wt === 1'b1);
    end
    do begin
      @(negedge clock_in);
      at = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clock_in);
    end while (at !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("write resp", 32'(re), 32'(rs));
  endtask : wr_reg

  task automatic rd_reg(input logic [31:0] a, exp, input logic [1:0] re);
    logic t;
    @(posedge clock_in);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clock_in);
      t = s_axi_arready;
      @(posedge clock_in);
    end while (t !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clock_in);
      t  = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock_in);
    end while (t !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("read data", exp, rd);
    chk("read resp", 32'(re), 32'(rs));
  endtask : rd_reg

  task automatic pulse(input int k);
    @(posedge clock_in);
    ev[k] <= 1'b1;
    @(posedge clock_in);
    ev[k] <= 1'b0;
  endtask : pulse

  task automatic wait_core(input logic v);
    n = 0;
    while (core_reset_out !== v && n < 2000) begin
      @(negedge clock_in);
      n++;
    end
    chk("core reset wait", 32'h1, 32'(n < 2000));
  endtask : wait_core

  // ------------------------------------------------------------
  // Flows
  // ------------------------------------------------------------
  task automatic por_run(input logic [5:0] st, input int src,
                         input logic [31:0] d, input int hold);
    @(posedge clock_in);
    {host_mode_strap_in, host_narrow_bus_strap_in,
     watchdog_enable_strap_in, boot_mode_select_in} <= st[4:0];
    cfg_host_data_in <= d;
    cfg_i2c_data_in  <= d;
    i_rstc_board.por_cycle(hold);
    @(negedge clock_in);
    chk("pll reset", 32'h1, 32'(system_pll_reset_out));
    repeat (5) @(posedge clock_in);
    pulse(src);
    chk("pll reset", 32'h0, 32'(system_pll_reset_out));
    n = 7;
    while (hard_reset_pin_oe_n_out !== 1'b1 && n < 600) begin
      @(negedge clock_in);
      n++;
    end
    chk("release gap", 32'h1, 32'(n >= 523 && n <= 525));
    wait_core(1'b0);
    rd_reg(RSTC_STRAP_OFF, 32'(st), RSTC_RESP_OKAY);
    rd_reg(RSTC_CFG_OFF, d, RSTC_RESP_OKAY);
    chk("config word", d, cfg_word_out);
    rd_reg(RSTC_CAUSE_OFF, (32'(hold < RSTC_POR_MIN_INPUT_REFERENCE_CLOCK) << RSTC_EV_PORSHRT)
           | 32'h01, RSTC_RESP_OKAY);
    chk("strap outputs", 32'(st), 32'(st_out));
    {host_mode_strap_in, host_narrow_bus_strap_in,
     watchdog_enable_strap_in, boot_mode_select_in} <= ~st[4:0];
    $display("Test power-on reset done");
  endtask : por_run

  task automatic flow(input int k, input logic [31:0] c);
    if (k < 0) i_rstc_board.pull_pin(4);
    else pulse(k);
    wait_core(1'b1);
    chk("pin released", 32'(c == 32'h10),
        32'(hard_reset_pin_oe_n_out));
    chk("soft reset", 32'(c == 32'h10),
        32'(soft_reset_internal_out));
    chk("pll reset", 32'h0, 32'(system_pll_reset_out));
    wait_core(1'b0);
    rd_reg(RSTC_CAUSE_OFF, c, RSTC_RESP_OKAY);
    rd_reg(RSTC_STRAP_OFF, 32'h14, RSTC_RESP_OKAY);
    rd_reg(RSTC_CFG_OFF, 32'hA5C3_0F1E, RSTC_RESP_OKAY);
    $display("Test reset flow %0h done", c);
  endtask : flow

  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    #400000;
    fails++;
    give_verdict();
  end

  initial begin
    {rstn_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, ev} = '0;
    {boot_mode_select_in, watchdog_enable_strap_in} = '0;
    {host_narrow_bus_strap_in, host_mode_strap_in} = '0;
    {cfg_host_data_in, cfg_i2c_data_in} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    por_run(6'h14, 3, 32'hA5C3_0F1E, RSTC_POR_MIN_INPUT_REFERENCE_CLOCK);
    wr_reg(RSTC_IMASK_OFF, 32'h00, RSTC_RESP_OKAY);
    chk("irq masked", 32'h0, 32'(irq_out));
    wr_reg(RSTC_IMASK_OFF, 32'h3F, RSTC_RESP_OKAY);
    chk("irq raised", 32'h1, 32'(irq_out));
    wr_reg(RSTC_ISTAT_OFF, 32'h01, RSTC_RESP_OKAY);
    chk("irq cleared", 32'h0, 32'(irq_out));
    flow(0, 32'h04);
    rd_reg(RSTC_ISTAT_OFF, 32'h04, RSTC_RESP_OKAY);
    chk("irq event", 32'h1, 32'(irq_out));
    wr_reg(RSTC_ISTAT_OFF, 32'h04, RSTC_RESP_OKAY);
    chk("irq cleared", 32'h0, 32'(irq_out));
    rd_reg(RSTC_CTRL_OFF, 32'(RSTC_CTRL_RESET), RSTC_RESP_OKAY);
    wr_reg(RSTC_CTRL_OFF, 32'h01, RSTC_RESP_OKAY);
    pulse(1);
    repeat (8) @(negedge clock_in);
    chk("disabled monitor", 32'h0, 32'(core_reset_out));
    wr_reg(RSTC_CTRL_OFF, 32'h03, RSTC_RESP_OKAY);
    flow(1, 32'h08);
    flow(-1, 32'h02);
    flow(2, 32'h10);
    rd_reg(32'h40, 32'h0, RSTC_RESP_SLVERR);
    wr_reg(32'h44, 32'h1, RSTC_RESP_SLVERR);
    wr_reg(RSTC_CAUSE_OFF, 32'h1F, RSTC_RESP_OKAY);
    rd_reg(RSTC_CAUSE_OFF, 32'h10, RSTC_RESP_OKAY);
    $display("Test register access done");
    por_run(6'h2B, 4, 32'h0F1E_A5C3, RSTC_POR_MIN_INPUT_REFERENCE_CLOCK - 1);
    give_verdict();
  end
endmodule : test_reset_controller

bind rstc_top rstc_monitor i_rstc_monitor (.*);
